// file: design/nfss_sync.sv
// two-stage synchroniser for the flash data pins
`timescale 1ns/10ps
`default_nettype none
module nfss_sync #(
    parameter int unsigned WIDTH = 8
) (
    // clock and control
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    // data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    // refused at elaboration: no bits to carry
    if (WIDTH < 1) begin : g_width_check
        $error("nfss_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : nfss_sync
`default_nettype wire

// file: design/nfss_top.sv
// nand flash strobe sequencer: chip select, latch enables, write and read strobes, data bus
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - chip select low one cycle before write strobe
// - chip select held three cycles after write
// - command latch held three cycles after write
// - address latch held three cycles after write
// - write data stable delay plus two cycles
// - write data held three cycles after rise
// - chip select low one cycle before read
// - chip select held three cycles after read
module nfss_top
    import nfss_pkg::*;
#(
    parameter int unsigned DLY_W = 4
) (
    // clock, reset, enable
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_ce,
    // request side
    input  wire logic                   i_req_valid,
    input  wire nfss_req_t              i_req,
    output logic                        o_req_ready,
    input  wire logic [DLY_W-1:0]       i_write_pulse_delay,
    input  wire logic [DLY_W-1:0]       i_read_pulse_delay,
    // read data return
    output logic [NFSS_DATA_W-1:0]      o_rd_data,
    output logic                        o_rd_valid,
    // flash pins
    output nfss_pins_t                  o_pins,
    output logic [NFSS_DATA_W-1:0]      o_data,
    output logic                        o_data_oe,
    input  wire logic [NFSS_DATA_W-1:0] i_data
);
    localparam int unsigned CNT_W = (DLY_W > 3) ? DLY_W : 3;

    nfss_state_t            state_r;
    nfss_state_t            state_nxt;
    logic [CNT_W-1:0]       cnt_r;
    logic [CNT_W-1:0]       cnt_nxt;
    nfss_op_t               op_r;
    nfss_op_t               op_nxt;
    logic [DLY_W-1:0]       dly_r;
    logic                   gap_r;
    logic                   pend_r;
    logic                   take;
    logic [NFSS_DATA_W-1:0] data_sync;

    // refused at elaboration: the low-width and data-age helper counters of the checks are eight bits wide
    if (DLY_W < 1 || DLY_W > 8) begin : g_dly_w_check
        $error("nfss_top: DLY_W must lie in 1..8");
    end

    nfss_sync #(
        .WIDTH     (NFSS_DATA_W)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_async   (i_data),
        .o_sync    (data_sync)
    );

    assign take   = i_req_valid && o_req_ready;
    assign op_nxt = take ? i_req.op : op_r;

    // sequence of one strobe and its recovery
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            NFSS_IDLE: begin
                if (take) begin
                    state_nxt = NFSS_SETUP;
                end
            end
            NFSS_SETUP: begin
                state_nxt = NFSS_LOW;
                cnt_nxt   = '0;
            end
            NFSS_LOW: begin
                if (cnt_r == CNT_W'(dly_r)) begin
                    state_nxt = NFSS_HIGH;
                    cnt_nxt   = '0;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            NFSS_HIGH: begin
                if (cnt_r == CNT_W'(NFSS_HIGH_LAST)) begin
                    cnt_nxt = '0;
                    if (!pend_r) begin
                        state_nxt = NFSS_IDLE;
                    end else if (gap_r) begin
                        state_nxt = NFSS_GAP;
                    end else begin
                        state_nxt = NFSS_LOW;
                    end
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            NFSS_GAP: begin
                state_nxt = NFSS_LOW;
                cnt_nxt   = '0;
            end
            default: begin
                state_nxt = NFSS_IDLE;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_r <= NFSS_IDLE;
            cnt_r   <= '0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // a new request is taken when idle or three cycles into the high time
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_req_ready <= 1'h0;
        end else if (i_ce) begin
            o_req_ready <= (state_nxt == NFSS_IDLE) ||
                           (state_nxt == NFSS_HIGH && cnt_nxt == CNT_W'(NFSS_ACCEPT_CNT));
        end
    end

    // latch the operation, its pulse delay and what must follow it
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            op_r   <= NFSS_OP_CMD;
            dly_r  <= '0;
            gap_r  <= 1'h0;
            pend_r <= 1'h0;
        end else if (i_ce) begin
            if (take) begin
                op_r   <= i_req.op;
                dly_r  <= (i_req.op == NFSS_OP_RDATA) ? i_read_pulse_delay : i_write_pulse_delay;
                gap_r  <= (state_r == NFSS_HIGH) && (op_r != NFSS_OP_RDATA) &&
                          (i_req.op == NFSS_OP_RDATA);
                pend_r <= (state_r == NFSS_HIGH);
            end else if (state_nxt != NFSS_HIGH) begin
                pend_r <= 1'h0;
            end
        end
    end

    // pins follow the next state so that they change on the state edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_pins.flash_chip_select_n  <= NFSS_CS_RST;
            o_pins.command_latch_enable <= NFSS_LATCH_RST;
            o_pins.address_latch_enable <= NFSS_LATCH_RST;
            o_pins.write_strobe_n       <= NFSS_STROBE_RST;
            o_pins.read_strobe_n        <= NFSS_STROBE_RST;
        end else if (i_ce) begin
            o_pins.flash_chip_select_n  <= (state_nxt == NFSS_IDLE);
            o_pins.command_latch_enable <= (state_nxt != NFSS_IDLE) && (op_nxt == NFSS_OP_CMD);
            o_pins.address_latch_enable <= (state_nxt != NFSS_IDLE) && (op_nxt == NFSS_OP_ADDR);
            o_pins.write_strobe_n       <= !((state_nxt == NFSS_LOW) && (op_nxt != NFSS_OP_RDATA));
            o_pins.read_strobe_n        <= !((state_nxt == NFSS_LOW) && (op_nxt == NFSS_OP_RDATA));
        end
    end

    // write data change only at a take, three cycles after the previous rise
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_data    <= '0;
            o_data_oe <= 1'h0;
        end else if (i_ce) begin
            if (take) begin
                o_data <= i_req.data;
            end
            o_data_oe <= (state_nxt != NFSS_IDLE) && (op_nxt != NFSS_OP_RDATA);
        end
    end

    // synchronised bus still shows the level just before the read strobe rose
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rd_data  <= '0;
            o_rd_valid <= 1'h0;
        end else if (i_ce) begin
            o_rd_valid <= 1'h0;
            if (state_r == NFSS_HIGH && cnt_r == CNT_W'(NFSS_SAMPLE_CNT) && op_r == NFSS_OP_RDATA) begin
                o_rd_data  <= data_sync;
                o_rd_valid <= 1'h1;
            end
        end
    end

    // helper counters read only by the checks below
    logic       strobe_low;
    logic [7:0] low_cnt_r;
    logic [7:0] data_age_r;
    logic [2:0] since_we_r;
    logic       we_prev_r;
    assign strobe_low = !o_pins.write_strobe_n || !o_pins.read_strobe_n;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            low_cnt_r  <= '0;
            data_age_r <= '0;
            since_we_r <= 3'h7;
            we_prev_r  <= 1'h1;
        end else if (i_ce) begin
            low_cnt_r  <= strobe_low ? low_cnt_r + 8'h01 : 8'h00;
            data_age_r <= take ? 8'h00 : ((data_age_r == 8'hFF) ? 8'hFF : data_age_r + 8'h01);
            we_prev_r  <= o_pins.write_strobe_n;
            if (o_pins.write_strobe_n && !we_prev_r) begin
                since_we_r <= 3'h1;
            end else if (since_we_r != 3'h7) begin
                since_we_r <= since_we_r + 3'h1;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n || !i_ce);

    a_cs_before_write: assert property ($fell(o_pins.write_strobe_n) |-> $past(!o_pins.flash_chip_select_n))
        else $error("write strobe fell without chip select a cycle earlier");
    a_cs_after_write: assert property ($rose(o_pins.write_strobe_n) |-> (!o_pins.flash_chip_select_n) [*4])
        else $error("chip select released too soon after write strobe");
    a_cmd_latch_hold: assert property ($rose(o_pins.write_strobe_n) && o_pins.command_latch_enable
                                       |-> o_pins.command_latch_enable [*3])
        else $error("command latch enable dropped too soon");
    a_addr_latch_hold: assert property ($rose(o_pins.write_strobe_n) && o_pins.address_latch_enable
                                        |-> o_pins.address_latch_enable [*3])
        else $error("address latch enable dropped too soon");
    a_data_setup_age: assert property ($rose(o_pins.write_strobe_n)
                                       |-> data_age_r >= 8'(dly_r) + 8'h02)
        else $error("write data not stable long enough before strobe rise");
    a_data_hold_oe: assert property ($rose(o_pins.write_strobe_n)
                                     |-> ($stable(o_data) && o_data_oe) [*3])
        else $error("write data not held after strobe rise");
    a_cs_before_read: assert property ($fell(o_pins.read_strobe_n) |-> $past(!o_pins.flash_chip_select_n))
        else $error("read strobe fell without chip select a cycle earlier");
    a_cs_after_read: assert property ($rose(o_pins.read_strobe_n) |-> (!o_pins.flash_chip_select_n) [*4])
        else $error("chip select released too soon after read strobe");
    a_strobe_low_width: assert property ($fell(strobe_low) |-> low_cnt_r == 8'(dly_r) + 8'h01)
        else $error("strobe low width differs from delay plus one");
    a_strobe_high_time: assert property ($fell(strobe_low) |-> !strobe_low [*4])
        else $error("strobe high time shorter than four cycles");
    a_write_read_gap: assert property ($fell(o_pins.read_strobe_n) |-> since_we_r >= 3'h5)
        else $error("read strobe fell too soon after write strobe rise");

    c_write_cycle: cover property ($rose(o_pins.write_strobe_n) ##4 o_pins.flash_chip_select_n);
    c_read_return: cover property (o_rd_valid);
    c_write_then_read: cover property ($rose(o_pins.write_strobe_n) ##[5:6] $fell(o_pins.read_strobe_n));
    c_back_to_back: cover property ($rose(o_pins.write_strobe_n) ##4 $fell(o_pins.write_strobe_n));
endmodule : nfss_top
`default_nettype wire

// file: pkg/nfss_pkg.sv
// package: request, pin and state types plus timing counts for the nand strobe sequencer
`default_nettype none
package nfss_pkg;
    localparam int unsigned NFSS_DATA_W      = 8;
    // cycle counts of the strobe sequence
    localparam int unsigned NFSS_CE_SETUP    = 1;
    localparam int unsigned NFSS_HIGH_CYC    = 4;
    localparam int unsigned NFSS_WR_RD_GAP   = 5;
    localparam int unsigned NFSS_LATCH_HOLD  = 3;
    localparam logic [2:0]  NFSS_ACCEPT_CNT  = 3'h2;
    localparam logic [2:0]  NFSS_HIGH_LAST   = 3'h3;
    localparam logic [2:0]  NFSS_SAMPLE_CNT  = 3'h1;
    // pin reset values
    localparam logic        NFSS_CS_RST      = 1'h1;
    localparam logic        NFSS_STROBE_RST  = 1'h1;
    localparam logic        NFSS_LATCH_RST   = 1'h0;

    typedef enum logic [1:0] {
        NFSS_OP_CMD   = 2'h0,
        NFSS_OP_ADDR  = 2'h1,
        NFSS_OP_WDATA = 2'h2,
        NFSS_OP_RDATA = 2'h3
    } nfss_op_t;

    typedef enum logic [2:0] {
        NFSS_IDLE  = 3'h0,
        NFSS_SETUP = 3'h1,
        NFSS_LOW   = 3'h3,
        NFSS_HIGH  = 3'h2,
        NFSS_GAP   = 3'h6
    } nfss_state_t;

    typedef struct packed {
        nfss_op_t               op;
        logic [NFSS_DATA_W-1:0] data;
    } nfss_req_t;

    typedef struct packed {
        logic flash_chip_select_n;
        logic command_latch_enable;
        logic address_latch_enable;
        logic write_strobe_n;
        logic read_strobe_n;
    } nfss_pins_t;
endpackage : nfss_pkg
`default_nettype wire

// file: tb/nfss_flash_model.sv
// flash device model: page byte written by data cycles, returned under the read strobe
`timescale 1ns/10ps
`default_nettype none
module nfss_flash_model
    import nfss_pkg::*;
(
    // clock and pins
    input  wire logic                   i_clk_sys,
    input  wire nfss_pins_t             i_pins,
    // data bus
    input  wire logic [NFSS_DATA_W-1:0] i_bus,
    output logic      [NFSS_DATA_W-1:0] o_data
);
    logic [NFSS_DATA_W-1:0] page_r;
    logic                   we_q_r;
    always_ff @(posedge i_clk_sys) begin
        we_q_r <= i_pins.write_strobe_n;
        // commands and addresses do not touch the page byte
        if (!we_q_r && i_pins.write_strobe_n && !i_pins.command_latch_enable && !i_pins.address_latch_enable) begin
            page_r <= i_bus;
        end
    end
    // outside a selected read pulse the line shows no valid byte
    assign o_data = (!i_pins.flash_chip_select_n && !i_pins.read_strobe_n) ? page_r : ~page_r;
endmodule : nfss_flash_model
`default_nettype wire

// file: tb/tb_nfss_top.sv
// self-checking bench for the nand strobe sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_nfss_top;
    import nfss_pkg::*;
    logic                   i_clk_sys, i_rst_n, i_ce, i_req_valid, o_req_ready, o_rd_valid, o_data_oe, prv_oe;
    nfss_req_t              i_req;
    nfss_pins_t             o_pins, prv;
    logic [3:0]             i_write_pulse_delay, i_read_pulse_delay;
    logic [NFSS_DATA_W-1:0] o_rd_data, o_data, flash_q, bus, dat_at_r, rd_got;
    logic [1:0]             lat_at_f;
    int                     miscompares, total_checks, cyc, rd_n;
    int                     cs_f, cs_r, wf, wf_prev, wr, rf, rr, lat_l, dat_f, dat_l;

    assign bus = o_data_oe ? o_data : flash_q;
    nfss_top nfss_top_i (.i_clk_sys, .i_rst_n, .i_ce, .i_req_valid, .i_req, .o_req_ready,
        .i_write_pulse_delay, .i_read_pulse_delay, .o_rd_data, .o_rd_valid, .o_pins, .o_data,
        .o_data_oe, .i_data(bus));
    nfss_flash_model nfss_flash_model_i (.i_clk_sys, .i_pins(o_pins), .i_bus(bus), .o_data(flash_q));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // pin edge monitor, cycle stamps of chip select and strobe edges, data enable rise, last latch and data enable cycles
    always @(posedge i_clk_sys) begin
        cyc = cyc + 1;
        if (prv.flash_chip_select_n && !o_pins.flash_chip_select_n) cs_f = cyc;
        if (!prv.flash_chip_select_n && o_pins.flash_chip_select_n) cs_r = cyc;
        if (prv.write_strobe_n && !o_pins.write_strobe_n) begin
            wf_prev = wf;
            wf = cyc;
            lat_at_f = {o_pins.command_latch_enable, o_pins.address_latch_enable};
        end
        if (!prv.write_strobe_n && o_pins.write_strobe_n) begin
            wr = cyc;
            dat_at_r = o_data;
        end
        if (prv.read_strobe_n && !o_pins.read_strobe_n) rf = cyc;
        if (!prv.read_strobe_n && o_pins.read_strobe_n) rr = cyc;
        if (o_pins.command_latch_enable || o_pins.address_latch_enable) lat_l = cyc;
        if (o_data_oe && !prv_oe) dat_f = cyc;
        if (o_data_oe) dat_l = cyc;
        if (o_rd_valid) begin
            rd_got = o_rd_data;
            rd_n++;
        end
        prv = o_pins;
        prv_oe = o_data_oe;
        if (cyc > 2000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // present a request and hold it until taken; returns just after the take edge
    task automatic req(input nfss_op_t op, input logic [7:0] d, input logic [3:0] dly);
        int n;
        n = 0;
        i_req_valid = 1'b1;
        i_req = '{op, d};
        // the delay not used by this op differs, so a swapped pick shows in the pulse width
        i_write_pulse_delay = (op == NFSS_OP_RDATA) ? ~dly : dly;
        i_read_pulse_delay = (op == NFSS_OP_RDATA) ? dly : ~dly;
        @(posedge i_clk_sys);
        while (o_req_ready !== 1'b1 && n < 50) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk("req_taken", o_req_ready, 1'b1);
        #1;
    endtask : req

    // release the request and wait for chip select to return high
    task automatic idle();
        int n;
        n = 0;
        i_req_valid = 1'b0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_pins.flash_chip_select_n !== 1'b1 && n < 40);
        chk("cs_released", o_pins.flash_chip_select_n, 1'b1);
        #1;
    endtask : idle

    task automatic t_write(input nfss_op_t op, input logic [7:0] d, input logic [3:0] dly);
        logic [1:0] lat;
        lat = (op == NFSS_OP_CMD) ? 2'h2 : (op == NFSS_OP_ADDR) ? 2'h1 : 2'h0;
        req(op, d, dly);
        idle();
        chk("we_cs_setup", wf - cs_f, 1);
        chk("we_low_len", wr - wf, dly + 1);
        chk("we_cs_hold", (cs_r - wr) >= 3, 1);
        chk("latch_at_fall", lat_at_f, lat);
        if (lat != 2'h0) chk("latch_hold", (lat_l - wr) >= 3, 1);
        chk("data_setup", (wr - dat_f) >= dly + 2, 1);
        chk("data_at_rise", dat_at_r, d);
        chk("data_hold", (dat_l - wr) >= 3, 1);
        $display("test write op %0d done", op);
    endtask : t_write

    task automatic t_read(input logic [3:0] dly, input logic [7:0] exp);
        rd_n = 0;
        req(NFSS_OP_RDATA, 8'h00, dly);
        idle();
        chk("re_cs_setup", rf - cs_f, 1);
        chk("re_low_len", rr - rf, dly + 1);
        chk("re_cs_hold", (cs_r - rr) >= 3, 1);
        chk("rd_count", rd_n, 1);
        chk("rd_data", rd_got, exp);
        $display("test read done");
    endtask : t_read

    // two chained writes then a chained read
    task automatic t_chain();
        rd_n = 0;
        req(NFSS_OP_WDATA, 8'h3C, 4'h1);
        req(NFSS_OP_WDATA, 8'hC3, 4'h1);
        req(NFSS_OP_RDATA, 8'h00, 4'h1);
        idle();
        chk("we_period", wf - wf_prev, 6);
        chk("we_to_re_gap", (rf - wr) >= 5, 1);
        chk("chain_rd_data", rd_got, 8'hC3);
        chk("chain_rd_count", rd_n, 1);
        $display("test chain done");
    endtask : t_chain

    // clock enable low just after a take freezes every pin, then the write completes normally
    task automatic t_freeze();
        nfss_pins_t held;
        req(NFSS_OP_WDATA, 8'h5A, 4'h2);
        i_ce = 1'b0;
        i_req_valid = 1'b0;
        held = o_pins;
        repeat (8) @(posedge i_clk_sys);
        #1;
        chk("frz_pins", o_pins, held);
        chk("frz_data", o_data, 8'h5A);
        i_ce = 1'b1;
        idle();
        chk("frz_we_low", wr - wf, 3);
        chk("frz_cs_hold", (cs_r - wr) >= 3, 1);
        $display("test freeze done");
    endtask : t_freeze

    initial begin
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_req_valid = 1'b0;
        i_req = '0;
        i_write_pulse_delay = 4'h0;
        i_read_pulse_delay = 4'h0;
        cyc = 0;
        miscompares = 0;
        total_checks = 0;
        // idle pin levels: chip select and strobes high, latches low
        prv = 5'h13;
        prv_oe = 1'b0;
        repeat (20) @(posedge i_clk_sys);
        #1 i_rst_n = 1'b1;
        t_write(NFSS_OP_CMD, 8'h70, 4'h0);
        t_write(NFSS_OP_ADDR, 8'h1F, 4'hF);
        t_write(NFSS_OP_WDATA, 8'hA5, 4'h3);
        t_read(4'h2, 8'hA5);
        t_chain();
        t_freeze();
        t_read(4'h0, 8'h5A);
        close_out();
    end
endmodule : tb_nfss_top
`default_nettype wire
